// ==== verilog/sacw_pkg.sv ====
// Package: register map, field layout, reset values and timing for the SAR ADC control block
`default_nettype none
package sacw_pkg;
  // ==========================================================================
  // Register addresses
  localparam logic [7:0] SACW_ADDR_CFG    = 8'hBC;
  localparam logic [7:0] SACW_ADDR_CHSEL  = 8'hBB;
  localparam logic [7:0] SACW_ADDR_PAIR   = 8'hBA;
  localparam logic [7:0] SACW_ADDR_RESL   = 8'hBE;
  localparam logic [7:0] SACW_ADDR_RESH   = 8'hBF;
  localparam logic [7:0] SACW_ADDR_UPL    = 8'hC4;
  localparam logic [7:0] SACW_ADDR_UPH    = 8'hC5;
  localparam logic [7:0] SACW_ADDR_LOL    = 8'hC6;
  localparam logic [7:0] SACW_ADDR_LOH    = 8'hC7;
  localparam logic [7:0] SACW_ADDR_CTL    = 8'hE8;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] SACW_RST_CFG     = 8'h60;
  localparam logic [7:0] SACW_RST_UPL     = 8'hFF;
  localparam logic [7:0] SACW_RST_UPH     = 8'hFF;
  localparam logic [7:0] SACW_RST_ZERO    = 8'h00;
  // ==========================================================================
  // Control register bit positions
  localparam int SACW_CTL_ON   = 7;
  localparam int SACW_CTL_TM   = 6;
  localparam int SACW_CTL_DONE = 5;
  localparam int SACW_CTL_BUSY = 4;
  localparam int SACW_CTL_STM1 = 3;
  localparam int SACW_CTL_STM0 = 2;
  localparam int SACW_CTL_WIN  = 1;
  localparam int SACW_CTL_JST  = 0;
  // Config register divider field
  localparam int SACW_CFG_DIV_HI = 7;
  localparam int SACW_CFG_DIV_LO = 5;
  // ==========================================================================
  // Timing and widths
  localparam int          SACW_RES_W       = 10;
  localparam int          SACW_CONV_CLKS   = 16;
  localparam int          SACW_TRACK_CLKS  = 3;
  localparam logic [4:0]  SACW_CNT_ZERO    = 5'h00;
  localparam logic [4:0]  SACW_CNT_ONE     = 5'h01;
  localparam logic [3:0]  SACW_TEMP_CODE   = 4'h8;
  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    SACW_STM_SOFT,
    SACW_STM_TMR3,
    SACW_STM_PIN,
    SACW_STM_TMR2
  } sacw_stm_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sacw_bus_t;

  typedef struct packed {
    logic       temp_sel;
    logic       diff;
    logic [2:0] pos_ch;
    logic [2:0] neg_ch;
  } sacw_mux_t;
endpackage : sacw_pkg
`default_nettype wire

// ==== verilog/sacw_clkdiv.sv ====
// SAR conversion clock divider producing a one-cycle tick
`timescale 1ns/1ps
`default_nettype none
module sacw_clkdiv
  import sacw_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       run,
  input  wire logic [2:0] div_code,
  // Tick out
  output logic            tick
);
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [4:0] period;
  // ==========================================================================
  // Period decode
  assign period = div_code[2] ? 5'h10 : (5'h01 << div_code[1:0]);
  assign tick   = run && (cnt_q == (period - SACW_CNT_ONE));
  assign cnt_d  = (!run || tick) ? SACW_CNT_ZERO : cnt_q + SACW_CNT_ONE;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= SACW_CNT_ZERO;
    else
      cnt_q <= cnt_d;
  end
endmodule : sacw_clkdiv
`default_nettype wire

// ==== verilog/sacw_window.sv ====
// Window comparator on the justified result word
`timescale 1ns/1ps
`default_nettype none
module sacw_window
  import sacw_pkg::*;
(
  // Compared words
  input  wire logic [15:0] result,
  input  wire logic [15:0] upper,
  input  wire logic [15:0] lower,
  // Outcome
  output logic             hit
);
  // ==========================================================================
  // Inside window when upper < lower, else outside
  logic in_band;
  assign in_band = upper < lower;
  assign hit     = in_band ? ((result > upper) && (result < lower))
                           : ((result > upper) || (result < lower));
endmodule : sacw_window
`default_nettype wire

// ==== verilog/sacw_top.sv ====
// SAR ADC control: mux select, sequencing, result formatting, window detect
`timescale 1ns/1ps
`default_nettype none
module sacw_top
  import sacw_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Special function register port
  input  wire sacw_pkg::sacw_bus_t    sfr,
  output logic [7:0]                  sfr_rdata,
  // Triggers
  input  wire logic                   timer2_overflow,
  input  wire logic                   timer3_overflow,
  input  wire logic                   external_start_pin,
  // Analog front end
  input  wire logic [9:0]             sar_data,
  output sacw_pkg::sacw_mux_t         mux_sel,
  output logic                        converter_on,
  output logic                        track_hold,
  output logic                        sar_active,
  // Interrupt requests
  output logic                        conv_done_irq,
  output logic                        window_irq
);
  // ==========================================================================
  // Registers
  typedef enum {SACW_IDLE, SACW_TRACK, SACW_CONV} sacw_state_t;
  sacw_state_t state_q;
  logic [7:0]  cfg_q, chsel_q, pair_q, ctl_q, upl_q, uph_q, lol_q, loh_q;
  logic [7:0]  resl_q, resh_q;
  logic [4:0]  cnt_q;
  logic        pin_q;
  logic        busy_q;
  logic        ev_done;
  // ==========================================================================
  // Decode
  wire wr_cfg   = sfr.wr && (sfr.addr == SACW_ADDR_CFG);
  wire wr_chsel = sfr.wr && (sfr.addr == SACW_ADDR_CHSEL);
  wire wr_pair  = sfr.wr && (sfr.addr == SACW_ADDR_PAIR);
  wire wr_ctl   = sfr.wr && (sfr.addr == SACW_ADDR_CTL);
  wire wr_upl   = sfr.wr && (sfr.addr == SACW_ADDR_UPL);
  wire wr_uph   = sfr.wr && (sfr.addr == SACW_ADDR_UPH);
  wire wr_lol   = sfr.wr && (sfr.addr == SACW_ADDR_LOL);
  wire wr_loh   = sfr.wr && (sfr.addr == SACW_ADDR_LOH);

  wire       en       = ctl_q[SACW_CTL_ON];
  // Enable as it stands after this edge, so a shutdown write stops work at once
  wire       en_nx    = wr_ctl ? sfr.wdata[SACW_CTL_ON] : en;
  wire       tmode    = ctl_q[SACW_CTL_TM];
  wire       justify  = ctl_q[SACW_CTL_JST];
  sacw_stm_t stm;
  assign stm = sacw_stm_t'(ctl_q[SACW_CTL_STM1:SACW_CTL_STM0]);

  // ==========================================================================
  // Trigger select
  wire pin_rise  = external_start_pin && !pin_q;
  wire soft_go   = wr_ctl && sfr.wdata[SACW_CTL_BUSY] && (stm == SACW_STM_SOFT);
  logic trig;
  assign trig = (stm == SACW_STM_SOFT) ? soft_go :
                (stm == SACW_STM_TMR3) ? timer3_overflow :
                (stm == SACW_STM_PIN)  ? pin_rise : timer2_overflow;
  // A trigger in the same cycle as a shutdown write is dropped
  wire start = en && en_nx && trig && (state_q == SACW_IDLE);

  // ==========================================================================
  // SAR clock
  logic sar_tick;
  sacw_clkdiv u_clkdiv (
    .clk      (clk),
    .rst_n    (rst_n),
    .run      (state_q != SACW_IDLE),
    .div_code (cfg_q[SACW_CFG_DIV_HI:SACW_CFG_DIV_LO]),
    .tick     (sar_tick)
  );

  // ==========================================================================
  // Sequencer
  // Pin mode with delayed tracking: the pin rise itself ends tracking
  wire delayed  = tmode && (stm != SACW_STM_PIN);
  wire trk_done = sar_tick && (cnt_q == 5'(SACW_TRACK_CLKS - 1));
  wire conv_end = sar_tick && (cnt_q == 5'(SACW_CONV_CLKS - 1));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= SACW_IDLE;
      cnt_q   <= SACW_CNT_ZERO;
    end
    else
    begin
      case (state_q)
        SACW_IDLE:
        begin
          cnt_q <= SACW_CNT_ZERO;
          if (start)
            state_q <= delayed ? SACW_TRACK : SACW_CONV;
        end
        SACW_TRACK:
        begin
          cnt_q <= sar_tick ? cnt_q + SACW_CNT_ONE : cnt_q;
          if (!en_nx)
            state_q <= SACW_IDLE;
          else if (trk_done)
          begin
            state_q <= SACW_CONV;
            cnt_q   <= SACW_CNT_ZERO;
          end
        end
        SACW_CONV:
        begin
          cnt_q <= sar_tick ? cnt_q + SACW_CNT_ONE : cnt_q;
          if (!en_nx || conv_end)
            state_q <= SACW_IDLE;
        end
        default:
          state_q <= SACW_IDLE;
      endcase
    end
  end

  // Busy falls on a completed conversion and also on a shutdown abort
  // Busy follows the next state, so it reads one from the first cycle of work
  wire busy_d = en_nx && (start || ((state_q != SACW_IDLE)
                                    && !(state_q == SACW_CONV && conv_end)));
  assign ev_done = busy_q && (state_q == SACW_CONV) && conv_end && en_nx;

  // ==========================================================================
  // Result and window
  wire [15:0] res_word = justify ? {sar_data, 6'h00} : {6'h00, sar_data};
  logic win_hit;
  sacw_window u_window (
    .result (res_word),
    .upper  ({uph_q, upl_q}),
    .lower  ({loh_q, lol_q}),
    .hit    (win_hit)
  );

  // Hardware set wins over a software clear in the same cycle
  wire done_d = (ev_done) ? 1'b1 :
                (wr_ctl ? sfr.wdata[SACW_CTL_DONE] & ctl_q[SACW_CTL_DONE]
                        : ctl_q[SACW_CTL_DONE]);
  wire win_d  = (ev_done && win_hit) ? 1'b1 :
                (wr_ctl ? sfr.wdata[SACW_CTL_WIN] & ctl_q[SACW_CTL_WIN]
                        : ctl_q[SACW_CTL_WIN]);

  // ==========================================================================
  // Register file
  // One short process per software-writable register keeps each write path easy to trace
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_q <= SACW_RST_CFG;
    else if (wr_cfg)
      cfg_q <= sfr.wdata;
  end

  // Unused upper bits are dropped on write so they always read zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      chsel_q <= SACW_RST_ZERO;
    else if (wr_chsel)
      chsel_q <= {4'h0, sfr.wdata[3:0]};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pair_q <= SACW_RST_ZERO;
    else if (wr_pair)
      pair_q <= {4'h0, sfr.wdata[3:0]};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      upl_q <= SACW_RST_UPL;
    else if (wr_upl)
      upl_q <= sfr.wdata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      uph_q <= SACW_RST_UPH;
    else if (wr_uph)
      uph_q <= sfr.wdata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lol_q <= SACW_RST_ZERO;
    else if (wr_lol)
      lol_q <= sfr.wdata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      loh_q <= SACW_RST_ZERO;
    else if (wr_loh)
      loh_q <= sfr.wdata;
  end

  // Flag and busy bits belong to hardware and override the written byte
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctl_q <= SACW_RST_ZERO;
    else
    begin
      if (wr_ctl)
        ctl_q <= sfr.wdata;
      ctl_q[SACW_CTL_DONE] <= done_d;
      ctl_q[SACW_CTL_WIN]  <= win_d;
      ctl_q[SACW_CTL_BUSY] <= busy_d;
    end
  end

  // Result bytes change only on a completed conversion, never on an abort
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resl_q <= SACW_RST_ZERO;
      resh_q <= SACW_RST_ZERO;
    end
    else if (ev_done)
    begin
      resl_q <= res_word[7:0];
      resh_q <= res_word[15:8];
    end
  end

  // Pin history resets low like the idle pin, so no false edge after reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_q  <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      pin_q  <= external_start_pin;
      busy_q <= busy_d;
    end
  end

  // ==========================================================================
  // Read mux
  always_comb
  begin
    case (sfr.addr)
      SACW_ADDR_CFG:   sfr_rdata = cfg_q;
      SACW_ADDR_CHSEL: sfr_rdata = chsel_q;
      SACW_ADDR_PAIR:  sfr_rdata = pair_q;
      SACW_ADDR_RESL:  sfr_rdata = resl_q;
      SACW_ADDR_RESH:  sfr_rdata = resh_q;
      SACW_ADDR_UPL:   sfr_rdata = upl_q;
      SACW_ADDR_UPH:   sfr_rdata = uph_q;
      SACW_ADDR_LOL:   sfr_rdata = lol_q;
      SACW_ADDR_LOH:   sfr_rdata = loh_q;
      SACW_ADDR_CTL:   sfr_rdata = ctl_q;
      default:         sfr_rdata = SACW_RST_ZERO;
    endcase
  end

  // ==========================================================================
  // Analog mux select
  wire [2:0] ch      = chsel_q[2:0];
  wire       pair_df = pair_q[ch[2:1]];
  always_comb
  begin
    mux_sel.temp_sel = chsel_q[3];
    mux_sel.diff     = !chsel_q[3] && pair_df;
    mux_sel.pos_ch   = pair_df ? {ch[2:1], 1'b0} : ch;
    mux_sel.neg_ch   = pair_df ? {ch[2:1], 1'b1} : 3'h0;
  end

  // ==========================================================================
  // Front end control
  assign converter_on  = en;
  assign sar_active    = (state_q == SACW_CONV);
  assign track_hold    = en && (tmode ? ((stm == SACW_STM_PIN) ? !external_start_pin
                                                               : (state_q == SACW_TRACK))
                                      : (state_q != SACW_CONV));
  assign conv_done_irq = ctl_q[SACW_CTL_DONE];
  assign window_irq    = ctl_q[SACW_CTL_WIN];
endmodule : sacw_top
`default_nettype wire

// ==== tb/sacw_checker.sv ====
// Checker: assertions on the SAR ADC control block ports
`timescale 1ns/1ps
`default_nettype none
module sacw_checker
  import sacw_pkg::*;
(
  // Clock and reset
  input wire logic                clk,
  input wire logic                rst_n,
  // Register port
  input wire sacw_pkg::sacw_bus_t sfr,
  input wire logic [7:0]          sfr_rdata,
  // Converter side
  input wire logic                converter_on,
  input wire logic                track_hold,
  input wire logic                sar_active,
  input wire logic                conv_done_irq,
  input wire logic                window_irq
);
  // ==========================================================================
  // Helper logic
  logic       ctl_wr;
  logic [2:0] div_q;
  logic [8:0] cnt_q;
  logic [8:0] per;
  assign ctl_wr = sfr.wr && (sfr.addr == SACW_ADDR_CTL);
  assign per    = div_q[2] ? 9'h010 : (9'h001 << div_q[1:0]);
  // Tracking cycles are left out, so one bound serves both tracking modes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q <= 3'h3;
      cnt_q <= 9'h000;
    end
    else
    begin
      if (sfr.wr && (sfr.addr == SACW_ADDR_CFG))
        div_q <= sfr.wdata[7:5];
      cnt_q <= (sar_active && !track_hold) ? cnt_q + 9'h001 : 9'h000;
    end
  end
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_conv_end;
    sar_active ##1 !sar_active;
  endsequence
  a_done_hold: assert property (
    conv_done_irq && !(ctl_wr && !sfr.wdata[5]) |=> conv_done_irq)
    else $error("done flag dropped without a clear");
  a_win_hold: assert property (
    window_irq && !(ctl_wr && !sfr.wdata[1]) |=> window_irq)
    else $error("window flag dropped without a clear");
  a_done_at_end: assert property (s_conv_end |-> conv_done_irq || !converter_on)
    else $error("conversion ended without done flag");
  a_off_idle: assert property (!converter_on |-> !sar_active)
    else $error("conversion while converter off");
  a_on_follows: assert property (ctl_wr |=> converter_on == $past(sfr.wdata[7]))
    else $error("converter enable not taken from write");
  a_no_track_conv: assert property (sar_active |-> !track_hold)
    else $error("tracking during conversion");
  a_conv_length: assert property (
    $rose(conv_done_irq) |-> cnt_q >= 9'(16 * per - 1) && cnt_q <= 9'(17 * per))
    else $error("conversion length wrong");
  a_flags_read: assert property (sfr.addr == SACW_ADDR_CTL |->
    sfr_rdata[1] == window_irq && sfr_rdata[5] == conv_done_irq)
    else $error("control read disagrees with flags");
endmodule : sacw_checker
bind sacw_top sacw_checker sacw_checker_i (.clk(clk), .rst_n(rst_n), .sfr(sfr),
  .sfr_rdata(sfr_rdata), .converter_on(converter_on), .track_hold(track_hold),
  .sar_active(sar_active), .conv_done_irq(conv_done_irq), .window_irq(window_irq));
`default_nettype wire

// ==== tb/tb_sacw_top.sv ====
// Testbench: self-checking scenarios for the SAR ADC control block
`timescale 1ns/1ps
`default_nettype none
module tb_sacw_top;
  import sacw_pkg::*;
  // ==========================================================================
  // Signals
  logic                clk = 1'b0, rst_n = 1'b0;
  logic                tmr2 = 1'b0, tmr3 = 1'b0, pin = 1'b0;
  sacw_pkg::sacw_bus_t sfr = '0;
  logic [9:0]          sar_data = 10'h000;
  logic [7:0]          rdata;
  sacw_pkg::sacw_mux_t mux_sel;
  logic                on, trk, act, done, win;
  int                  error_cnt = 0, n_compared = 0;
  always #4 clk = ~clk;
  sacw_top sacw_top_i (.clk(clk), .rst_n(rst_n), .sfr(sfr), .sfr_rdata(rdata),
    .timer2_overflow(tmr2), .timer3_overflow(tmr3), .external_start_pin(pin),
    .sar_data(sar_data), .mux_sel(mux_sel), .converter_on(on), .track_hold(trk),
    .sar_active(act), .conv_done_irq(done), .window_irq(win));
  // ==========================================================================
  // Shared tasks
  task automatic end_of_test();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk) sfr.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) sfr.addr <= a;
    #1 check(16'(rdata), 16'(exp));
  endtask : rd
  // Polls the control register; a lost completion ends the run
  task automatic wait_done(input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
      if (n == 1)
        check(16'(rdata[4]), 16'h0001);
    end
    while (rdata[5] !== 1'b1 && n < lim);
    if (rdata[5] !== 1'b1)
    begin
      error_cnt++;
      $display("mismatch at %0t: no completion", $time);
      end_of_test();
    end
    check(16'(rdata[4]), 16'h0000);
  endtask : wait_done
  task automatic conv(input logic [7:0] ctl, input logic [9:0] d, output int n);
    @(posedge clk) sar_data <= d;
    wr(SACW_ADDR_CTL, ctl);
    wait_done(300, n);
  endtask : conv
  // ==========================================================================
  // Scenarios
  task automatic t_mux();
    logic [7:0] t [4][4] = '{'{8'h01, 8'h01, 8'h41, 8'hFF}, '{8'h08, 8'h07, 8'h77, 8'hFF},
      '{8'h00, 8'h05, 8'h28, 8'hF8}, '{8'hFF, 8'h0A, 8'h80, 8'h80}};
    rd(SACW_ADDR_CFG, 8'h60);
    rd(SACW_ADDR_UPL, 8'hFF);
    rd(SACW_ADDR_LOL, 8'h00);
    rd(SACW_ADDR_LOH, 8'h00);
    rd(8'h01, 8'h00);
    foreach (t[i])
    begin
      wr(SACW_ADDR_PAIR, t[i][0]);
      wr(SACW_ADDR_CHSEL, t[i][1]);
      check(16'(mux_sel & t[i][3]), 16'(t[i][2]));
    end
    rd(SACW_ADDR_PAIR, 8'h0F);
  endtask : t_mux
  task automatic t_divider();
    int n;
    wr(SACW_ADDR_CTL, 8'h80);
    for (int c = 0; c < 5; c++)
    begin
      wr(SACW_ADDR_CFG, (c == 4) ? 8'hE0 : 8'(c << 5));
      conv(8'h90, 10'h2A5, n);
      check(16'(n), 16'(16 << c));
      rd(SACW_ADDR_RESL, 8'hA5);
      rd(SACW_ADDR_RESH, 8'h02);
      wr(SACW_ADDR_CTL, 8'h80);
      rd(SACW_ADDR_CTL, 8'h80);
    end
    wr(SACW_ADDR_CFG, 8'h00);
    wr(SACW_ADDR_CTL, 8'hC1);
    conv(8'hD1, 10'h2A5, n);
    check(16'(n), 16'd19);
    rd(SACW_ADDR_RESH, 8'hA9);
    rd(SACW_ADDR_RESL, 8'h40);
    wr(SACW_ADDR_CTL, 8'h80);
  endtask : t_divider
  task automatic t_window();
    logic [15:0] t [5][4] = '{'{16'h01, 16'h02, 16'h180, 16'h1},
      '{16'h03, 16'h01, 16'h180, 16'h0}, '{16'h03, 16'h01, 16'h350, 16'h1},
      '{16'h03, 16'h01, 16'h050, 16'h1}, '{16'h01, 16'h02, 16'h050, 16'h0}};
    int n;
    wr(SACW_ADDR_UPL, 8'h00);
    foreach (t[i])
    begin
      wr(SACW_ADDR_UPH, t[i][0][7:0]);
      wr(SACW_ADDR_LOH, t[i][1][7:0]);
      conv(8'h90, t[i][2][9:0], n);
      check(16'(win), t[i][3]);
      wr(SACW_ADDR_CTL, 8'h80);
    end
    rd(SACW_ADDR_UPH, 8'h01);
    rd(SACW_ADDR_UPL, 8'h00);
    conv(8'h90, 10'h180, n);
    wr(SACW_ADDR_CTL, 8'h82);
    rd(SACW_ADDR_CTL, 8'h82);
    conv(8'h92, 10'h050, n);
    check(16'(win), 16'h0001);
    wr(SACW_ADDR_CTL, 8'hA2);
    rd(SACW_ADDR_CTL, 8'hA2);
    wr(SACW_ADDR_CTL, 8'h80);
  endtask : t_window
  task automatic t_triggers();
    logic [7:0] ctl [5] = '{8'h84, 8'h8C, 8'h88, 8'h84, 8'h04};
    int         src [5] = '{3, 2, 0, 2, 3};
    int         n;
    for (int i = 0; i < 5; i++)
    begin
      wr(SACW_ADDR_CTL, ctl[i]);
      @(posedge clk)
      begin
        tmr2 <= (src[i] == 2);
        tmr3 <= (src[i] == 3);
        pin  <= (src[i] == 0);
      end
      @(posedge clk) {tmr2, tmr3, pin} <= 3'h0;
      if (i < 3)
        wait_done(40, n);
      else
      begin
        repeat (40) @(posedge clk);
        #1 check(16'(rdata[5]), 16'h0000);
      end
      wr(SACW_ADDR_CTL, 8'h80);
    end
    wr(SACW_ADDR_CTL, 8'h90);
    wr(SACW_ADDR_CTL, 8'h00);
    rd(SACW_ADDR_CTL, 8'h00);
    check(16'(act), 16'h0000);
    check(16'(on), 16'h0000);
    repeat (20) @(posedge clk);
    #1 check(16'(done), 16'h0000);
  endtask : t_triggers
  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_mux();
    t_divider();
    t_window();
    t_triggers();
    end_of_test();
  end
endmodule : tb_sacw_top
`default_nettype wire
